/* rtl/alarm_level_detect.sv */
// threshold alarm with release only above the threshold
`timescale 1ns/100ps
module alarm_level_detect (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] level_i,
  input wire logic [15:0] threshold_i,
  output logic active_o
);
  // zero threshold disables, equal level holds the present state
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_o <= 1'b0;
    end else if (threshold_i == gauge_pkg::ZERO16) begin
      active_o <= 1'b0;
    end else if (level_i < threshold_i) begin
      active_o <= 1'b1;
    end else if (level_i > threshold_i) begin
      active_o <= 1'b0;
    end
  end
endmodule : alarm_level_detect

/* rtl/charge_init_engine.sv */
// open-circuit voltage to charge level conversion with completion bound
`timescale 1ns/100ps
module charge_init_engine #(
  parameter int LIMIT_CYC = gauge_pkg::INIT_MAX_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [15:0] volt_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] permille_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WALK = 3'b010,
    ST_DONE = 3'b100
  } eng_state_type;

  // curve point voltage in mV for a table index
  function automatic logic [15:0] ocv_mv(input logic [3:0] idx);
    case (idx)
      4'h0: ocv_mv = 16'h0BB8;
      4'h1: ocv_mv = 16'h0DAC;
      4'h2: ocv_mv = 16'h0E10;
      4'h3: ocv_mv = 16'h0E42;
      4'h4: ocv_mv = 16'h0E74;
      4'h5: ocv_mv = 16'h0EA6;
      4'h6: ocv_mv = 16'h0ED8;
      4'h7: ocv_mv = 16'h0F0A;
      4'h8: ocv_mv = 16'h0F3C;
      4'h9: ocv_mv = 16'h0F6E;
      default: ocv_mv = 16'h1068;
    endcase
  endfunction : ocv_mv

  eng_state_type state_reg;
  logic [3:0] idx_reg;
  logic [15:0] volt_reg;
  logic [31:0] timer_reg;
  logic last_w;

  // stop at the top point or where the next point is above the sample
  assign last_w = (idx_reg == 4'(gauge_pkg::OCV_POINTS - 1)) ||
                  (volt_reg < ocv_mv(idx_reg + 4'h1)) ||
                  (timer_reg >= 32'(LIMIT_CYC - 2));

  // sequencer walking the curve, one point per cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      idx_reg <= 4'h0;
      volt_reg <= 16'h0000;
      timer_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        ST_IDLE, ST_DONE: begin
          // a start in the result cycle is taken, not dropped
          idx_reg <= 4'h0;
          timer_reg <= 32'h0000_0000;
          state_reg <= ST_IDLE;
          if (start_i) begin
            volt_reg <= volt_i;
            state_reg <= ST_WALK;
          end
        end
        ST_WALK: begin
          timer_reg <= timer_reg + 32'h0000_0001;
          if (last_w) begin
            state_reg <= ST_DONE;
          end else begin
            idx_reg <= idx_reg + 4'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // result and status flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      permille_o <= 16'h0000;
    end else begin
      done_o <= (state_reg == ST_WALK) && last_w;
      busy_o <= start_i || ((state_reg == ST_WALK) && !last_w);
      if ((state_reg == ST_WALK) && last_w) begin
        if (volt_reg < ocv_mv(4'h0)) begin
          permille_o <= 16'h0000;
        end else begin
          permille_o <= 16'(idx_reg * gauge_pkg::PERMILLE_STEP);
        end
      end
    end
  end
endmodule : charge_init_engine

/* rtl/fuel_gauge_register_bank.sv */
// command-addressed register bank of the single-cell charge estimator
// Functional notes
// - after reset the charge level is set from the first measured voltage
// - 0xAA55 to 0x04 re-initializes from highest voltage since reset
// - 0xAA55 to 0x07 re-initializes from the present voltage
// - re-initialization finishes within 1.5 ms of the write
// - thermistor beta register is read/write, resets to 0x0D34
// - temperature reads in 0.1K; host writes 0x09E4..0x0D04 in host mode
// - cell voltage is read-only in mV
// - direction 0x0000 auto, 0x0001 charge, 0xFFFF discharge; reset auto
// - charge mode estimates never lower level, discharge mode estimates never raise it
// - thermistor delay adjust at 0x0C is read/write
// - percent register reads 0..100 and accepts writes
// - per-mille register is read-only, 0..1000
// - profile select takes only 0 or 1, resets to 0
// - low charge threshold 1..100, zero disables, resets to 8
// - alarm pin low while level below threshold, released above it
// - low voltage threshold 1..0xFFFF mV, zero disables, resets to zero
// - power mode 0x0001 operational, 0x0002 sleep
// - sleep keeps the bus, alarms and re-initialization; measuring and tracking need operation
// - 0x1A reads the profile file code
// - 0x11 reads the chip identification number
`timescale 1ns/100ps
module fuel_gauge_register_bank #(
  parameter int INIT_LIMIT_CYC = gauge_pkg::INIT_MAX_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] cmd_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] vbat_mv_i,
  input wire logic vbat_valid_i,
  input wire logic [15:0] therm_temp_i,
  input wire logic therm_valid_i,
  input wire logic [15:0] est_permille_i,
  input wire logic est_valid_i,
  output logic [15:0] rdata_o,
  output logic rvalid_o,
  output logic alarm_out_n_o,
  output logic operational_o,
  output logic therm_mode_o,
  output logic init_busy_o,
  output logic [15:0] therm_beta_o,
  output logic [15:0] therm_delay_o,
  output logic [15:0] imp_adjust_o,
  output logic profile_sel_o
);
  // ==========================================================
  // register state
  logic [15:0] beta_reg;
  logic [15:0] temp_reg;
  logic [15:0] volt_reg;
  logic [15:0] volt_max_reg;
  logic [15:0] dir_reg;
  logic [15:0] imp_reg;
  logic [15:0] delay_reg;
  logic [15:0] permille_reg;
  logic [15:0] profile_reg;
  logic [15:0] low_chg_reg;
  logic [15:0] low_volt_reg;
  logic [15:0] mode_reg;
  logic [15:0] src_reg;
  logic volt_seen_reg;
  logic auto_init_reg;
  logic [15:0] percent_w;
  logic operate_w;
  logic eng_start_w;
  logic [15:0] eng_volt_w;
  logic eng_busy_w;
  logic eng_done_w;
  logic [15:0] eng_permille_w;
  logic chg_alarm_w;
  logic volt_alarm_w;

  // write to one command code
  function automatic logic wr_hit(input logic wr, input logic [7:0] cmd,
                                  input logic [7:0] code);
    wr_hit = wr && (cmd == code);
  endfunction : wr_hit

  // accepted direction codes
  function automatic logic dir_ok(input logic [15:0] v);
    dir_ok = (v == gauge_pkg::DIR_AUTO) || (v == gauge_pkg::DIR_CHARGE) ||
             (v == gauge_pkg::DIR_DISCHARGE);
  endfunction : dir_ok

  // ==========================================================
  // derived levels
  assign operate_w = (mode_reg == gauge_pkg::MODE_OPERATE);
  assign percent_w = 16'(permille_reg / gauge_pkg::PERMILLE_PER_PCT);

  // ==========================================================
  // initialization requests
  always_comb begin
    eng_start_w = 1'b0;
    eng_volt_w = volt_reg;
    if (!eng_busy_w) begin
      if (wr_hit(wr_i, cmd_i, gauge_pkg::CMD_INIT_HISTORY) &&
          (wdata_i == gauge_pkg::INIT_KEY)) begin
        eng_start_w = 1'b1;
        eng_volt_w = volt_max_reg;
      end else if (wr_hit(wr_i, cmd_i, gauge_pkg::CMD_INIT_NOW) &&
                   (wdata_i == gauge_pkg::INIT_KEY)) begin
        eng_start_w = 1'b1;
      end else if (auto_init_reg && volt_seen_reg) begin
        eng_start_w = 1'b1;
      end
    end
  end

  charge_init_engine #(
    .LIMIT_CYC(INIT_LIMIT_CYC)
  ) u_init (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .start_i(eng_start_w),
    .volt_i(eng_volt_w),
    .busy_o(eng_busy_w),
    .done_o(eng_done_w),
    .permille_o(eng_permille_w)
  );

  // automatic start once the first voltage sample is in
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      auto_init_reg <= 1'b1;
    end else if (eng_start_w) begin
      auto_init_reg <= 1'b0;
    end
  end

  // ==========================================================
  // voltage measurement and history maximum
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      volt_reg <= 16'h0000;
      volt_max_reg <= 16'h0000;
      volt_seen_reg <= 1'b0;
    end else if (vbat_valid_i && operate_w) begin
      volt_reg <= vbat_mv_i;
      volt_seen_reg <= 1'b1;
      if (vbat_mv_i > volt_max_reg) begin
        volt_max_reg <= vbat_mv_i;
      end
    end
  end

  // ==========================================================
  // cell temperature from host or thermistor
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      temp_reg <= gauge_pkg::TEMP_RST;
    end else if (src_reg == gauge_pkg::SRC_THERM) begin
      if (therm_valid_i && operate_w) begin
        temp_reg <= therm_temp_i;
      end
    end else if (wr_hit(wr_i, cmd_i, gauge_pkg::CMD_CELL_TEMP) &&
                 (wdata_i >= gauge_pkg::TEMP_MIN) &&
                 (wdata_i <= gauge_pkg::TEMP_MAX)) begin
      temp_reg <= wdata_i;
    end
  end

  // ==========================================================
  // charge level tracking
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      permille_reg <= 16'h0000;
    end else if (eng_done_w) begin
      permille_reg <= eng_permille_w;
    end else if (wr_hit(wr_i, cmd_i, gauge_pkg::CMD_PERCENT) &&
                 (wdata_i <= gauge_pkg::PERCENT_MAX)) begin
      permille_reg <= 16'(wdata_i * gauge_pkg::PERMILLE_PER_PCT);
    end else if (est_valid_i && operate_w &&
                 (est_permille_i <= gauge_pkg::PERMILLE_MAX)) begin
      case (dir_reg)
        gauge_pkg::DIR_CHARGE: begin
          if (est_permille_i > permille_reg) begin
            permille_reg <= est_permille_i;
          end
        end
        gauge_pkg::DIR_DISCHARGE: begin
          if (est_permille_i < permille_reg) begin
            permille_reg <= est_permille_i;
          end
        end
        default: permille_reg <= est_permille_i;
      endcase
    end
  end

  // ==========================================================
  // settings written by the host
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      beta_reg <= gauge_pkg::BETA_RST;
      dir_reg <= gauge_pkg::DIR_AUTO;
      imp_reg <= gauge_pkg::IMP_RST;
      delay_reg <= gauge_pkg::DELAY_RST;
      profile_reg <= gauge_pkg::ZERO16;
      low_chg_reg <= gauge_pkg::LOW_CHG_RST;
      low_volt_reg <= gauge_pkg::ZERO16;
      mode_reg <= gauge_pkg::MODE_RST;
      src_reg <= gauge_pkg::SRC_HOST;
    end else if (wr_i) begin
      case (cmd_i)
        gauge_pkg::CMD_THERM_BETA: beta_reg <= wdata_i;
        gauge_pkg::CMD_CUR_DIR: begin
          if (dir_ok(wdata_i)) begin
            dir_reg <= wdata_i;
          end
        end
        gauge_pkg::CMD_IMP_ADJ: begin
          if (wdata_i <= gauge_pkg::IMP_MAX) begin
            imp_reg <= wdata_i;
          end
        end
        gauge_pkg::CMD_THERM_DELAY: delay_reg <= wdata_i;
        gauge_pkg::CMD_PROFILE_SEL: begin
          if (wdata_i <= gauge_pkg::PROFILE_MAX) begin
            profile_reg <= wdata_i;
          end
        end
        gauge_pkg::CMD_LOW_CHG_THR: begin
          if (wdata_i <= gauge_pkg::PERCENT_MAX) begin
            low_chg_reg <= wdata_i;
          end
        end
        gauge_pkg::CMD_LOW_VOLT_THR: low_volt_reg <= wdata_i;
        gauge_pkg::CMD_POWER_MODE: begin
          if ((wdata_i == gauge_pkg::MODE_OPERATE) ||
              (wdata_i == gauge_pkg::MODE_SLEEP)) begin
            mode_reg <= wdata_i;
          end
        end
        gauge_pkg::CMD_TEMP_SRC: begin
          if ((wdata_i == gauge_pkg::SRC_HOST) ||
              (wdata_i == gauge_pkg::SRC_THERM)) begin
            src_reg <= wdata_i;
          end
        end
        default: ; // read-only and unknown codes change nothing
      endcase
    end
  end

  // ==========================================================
  // alarms
  alarm_level_detect u_chg_alarm (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .level_i(percent_w),
    .threshold_i(low_chg_reg),
    .active_o(chg_alarm_w)
  );

  alarm_level_detect u_volt_alarm (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .level_i(volt_reg),
    .threshold_i(low_volt_reg),
    .active_o(volt_alarm_w)
  );

  // ==========================================================
  // read port, answer one cycle after the strobe
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
      if (rd_i) begin
        case (cmd_i)
          gauge_pkg::CMD_THERM_BETA: rdata_o <= beta_reg;
          gauge_pkg::CMD_CELL_TEMP: rdata_o <= temp_reg;
          gauge_pkg::CMD_CELL_VOLT: rdata_o <= volt_reg;
          gauge_pkg::CMD_CUR_DIR: rdata_o <= dir_reg;
          gauge_pkg::CMD_IMP_ADJ: rdata_o <= imp_reg;
          gauge_pkg::CMD_THERM_DELAY: rdata_o <= delay_reg;
          gauge_pkg::CMD_PERCENT: rdata_o <= percent_w;
          gauge_pkg::CMD_PERMILLE: rdata_o <= permille_reg;
          gauge_pkg::CMD_CHIP_VER: rdata_o <= gauge_pkg::CHIP_VER_VAL;
          gauge_pkg::CMD_PROFILE_SEL: rdata_o <= profile_reg;
          gauge_pkg::CMD_LOW_CHG_THR: rdata_o <= low_chg_reg;
          gauge_pkg::CMD_LOW_VOLT_THR: rdata_o <= low_volt_reg;
          gauge_pkg::CMD_POWER_MODE: rdata_o <= mode_reg;
          gauge_pkg::CMD_TEMP_SRC: rdata_o <= src_reg;
          gauge_pkg::CMD_PROFILE_ID: rdata_o <= gauge_pkg::PROFILE_ID_VAL;
          default: rdata_o <= gauge_pkg::ZERO16; // write-only or unmapped
        endcase
      end
    end
  end

  // ==========================================================
  // status and setting outputs
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_out_n_o <= 1'b1;
      operational_o <= 1'b0;
      therm_mode_o <= 1'b0;
      init_busy_o <= 1'b0;
      therm_beta_o <= gauge_pkg::BETA_RST;
      therm_delay_o <= gauge_pkg::DELAY_RST;
      imp_adjust_o <= gauge_pkg::IMP_RST;
      profile_sel_o <= 1'b0;
    end else begin
      alarm_out_n_o <= !(chg_alarm_w || volt_alarm_w);
      operational_o <= operate_w;
      therm_mode_o <= (src_reg == gauge_pkg::SRC_THERM) && operate_w;
      init_busy_o <= eng_busy_w;
      therm_beta_o <= beta_reg;
      therm_delay_o <= delay_reg;
      imp_adjust_o <= imp_reg;
      profile_sel_o <= profile_reg[0];
    end
  end
endmodule : fuel_gauge_register_bank

/* rtl/gauge_pkg.sv */
// constants shared by the charge estimator register bank
package gauge_pkg;
  // command codes
  localparam logic [7:0] CMD_INIT_HISTORY = 8'h04;
  localparam logic [7:0] CMD_THERM_BETA = 8'h06;
  localparam logic [7:0] CMD_INIT_NOW = 8'h07;
  localparam logic [7:0] CMD_CELL_TEMP = 8'h08;
  localparam logic [7:0] CMD_CELL_VOLT = 8'h09;
  localparam logic [7:0] CMD_CUR_DIR = 8'h0A;
  localparam logic [7:0] CMD_IMP_ADJ = 8'h0B;
  localparam logic [7:0] CMD_THERM_DELAY = 8'h0C;
  localparam logic [7:0] CMD_PERCENT = 8'h0D;
  localparam logic [7:0] CMD_PERMILLE = 8'h0F;
  localparam logic [7:0] CMD_CHIP_VER = 8'h11;
  localparam logic [7:0] CMD_PROFILE_SEL = 8'h12;
  localparam logic [7:0] CMD_LOW_CHG_THR = 8'h13;
  localparam logic [7:0] CMD_LOW_VOLT_THR = 8'h14;
  localparam logic [7:0] CMD_POWER_MODE = 8'h15;
  localparam logic [7:0] CMD_TEMP_SRC = 8'h16;
  localparam logic [7:0] CMD_PROFILE_ID = 8'h1A;
  // values and ranges
  localparam logic [15:0] INIT_KEY = 16'hAA55;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] BETA_RST = 16'h0D34;
  localparam logic [15:0] TEMP_RST = 16'h0BA6;
  localparam logic [15:0] TEMP_MIN = 16'h09E4;
  localparam logic [15:0] TEMP_MAX = 16'h0D04;
  localparam logic [15:0] DIR_AUTO = 16'h0000;
  localparam logic [15:0] DIR_CHARGE = 16'h0001;
  localparam logic [15:0] DIR_DISCHARGE = 16'hFFFF;
  localparam logic [15:0] IMP_MAX = 16'h00FF;
  localparam logic [15:0] IMP_RST = 16'h0000;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [15:0] PERCENT_MAX = 16'h0064;
  localparam logic [15:0] PERMILLE_MAX = 16'h03E8;
  localparam logic [15:0] PERMILLE_PER_PCT = 16'h000A;
  localparam logic [15:0] PROFILE_MAX = 16'h0001;
  localparam logic [15:0] LOW_CHG_RST = 16'h0008;
  localparam logic [15:0] MODE_OPERATE = 16'h0001;
  localparam logic [15:0] MODE_SLEEP = 16'h0002;
  localparam logic [15:0] MODE_RST = 16'h0001;
  localparam logic [15:0] SRC_HOST = 16'h0000;
  localparam logic [15:0] SRC_THERM = 16'h0001;
  localparam logic [15:0] CHIP_VER_VAL = 16'h1234; // arbitrary value
  localparam logic [15:0] PROFILE_ID_VAL = 16'h0A0B; // arbitrary value
  // open-circuit voltage curve, 11 points, step of 100 per mille
  localparam int OCV_POINTS = 11;
  localparam logic [15:0] PERMILLE_STEP = 16'h0064;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int INIT_MAX_NS = 1500000; // 1.5 ms
  localparam int INIT_MAX_CYC = INIT_MAX_NS / CLK_PERIOD_NS;
endpackage : gauge_pkg

/* verification/fuel_gauge_register_bank_tb.sv */
// self-checking bench for the charge estimator register bank
`timescale 1ns/100ps
module fuel_gauge_register_bank_tb;
  // ==========================================================
  // signals
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] cmd;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] vbat = 16'h0000;
  logic vbat_valid = 1'b0;
  logic [15:0] therm = 16'h0000;
  logic therm_valid = 1'b0;
  logic [15:0] est = 16'h0000;
  logic est_valid = 1'b0;
  logic [15:0] rdata;
  logic rvalid;
  logic alarm_n;
  logic oper;
  logic therm_mode;
  logic busy;
  logic [15:0] beta;
  logic [15:0] dly_adj;
  logic [15:0] imp;
  logic prof;
  int error_cnt = 0;
  int samples_checked = 0;
  // 50 MHz clock
  always #10 mclk = ~mclk;
  // ==========================================================
  // design and host model
  fuel_gauge_register_bank #(.INIT_LIMIT_CYC(50)) i_dut (
    .mclk_i(mclk), .rst_n_i(rst_n), .cmd_i(cmd), .wr_i(wr), .rd_i(rd),
    .wdata_i(wdata), .vbat_mv_i(vbat), .vbat_valid_i(vbat_valid),
    .therm_temp_i(therm), .therm_valid_i(therm_valid),
    .est_permille_i(est), .est_valid_i(est_valid), .rdata_o(rdata),
    .rvalid_o(rvalid), .alarm_out_n_o(alarm_n), .operational_o(oper),
    .therm_mode_o(therm_mode), .init_busy_o(busy), .therm_beta_o(beta),
    .therm_delay_o(dly_adj), .imp_adjust_o(imp), .profile_sel_o(prof));
  host_bus_model i_host (
    .mclk_i(mclk), .rvalid_i(rvalid), .rdata_i(rdata), .cmd_o(cmd),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  // ==========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] v;
    i_host.read_word(c, v);
    check(v, exp);
  endtask : rdchk
  task automatic wrchk(input logic [7:0] c, input logic [15:0] d,
                       input logic [15:0] exp);
    i_host.write_word(c, d);
    rdchk(c, exp);
  endtask : wrchk
  // one sample pulse: 0 battery, 1 thermistor, 2 estimator
  task automatic meas(input int kind, input logic [15:0] v);
    @(negedge mclk);
    vbat = v;
    therm = v;
    est = v;
    vbat_valid = (kind == 0);
    therm_valid = (kind == 1);
    est_valid = (kind == 2);
    @(negedge mclk);
    vbat_valid = 1'b0;
    therm_valid = 1'b0;
    est_valid = 1'b0;
  endtask : meas
  // bounded wait for a charge initialization to finish
  task automatic wait_init();
    int n;
    n = 0;
    // busy shows two edges after the request
    repeat (3) @(negedge mclk);
    while (busy === 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    check({15'h0000, busy}, 16'h0000);
  endtask : wait_init
  task automatic alarm_is(input logic exp);
    repeat (3) @(negedge mclk);
    check({15'h0000, alarm_n}, {15'h0000, exp});
  endtask : alarm_is
  task automatic conclude();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  // watchdog
  initial begin
    #400000;
    error_cnt++;
    conclude();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    // reset values and fixed codes
    rdchk(8'h06, 16'h0D34);
    rdchk(8'h08, 16'h0BA6);
    rdchk(8'h0A, 16'h0000);
    rdchk(8'h12, 16'h0000);
    rdchk(8'h13, 16'h0008);
    rdchk(8'h14, 16'h0000);
    rdchk(8'h16, 16'h0000);
    rdchk(8'h11, gauge_pkg::CHIP_VER_VAL);
    rdchk(8'h1A, gauge_pkg::PROFILE_ID_VAL);
    rdchk(8'h07, 16'h0000);
    rdchk(8'h3E, 16'h0000);
    i_host.write_word(8'h15, 16'h0001);
    // access kinds and refused values
    wrchk(8'h06, 16'hFFFF, 16'hFFFF);
    check(beta, 16'hFFFF);
    wrchk(8'h0C, 16'h1234, 16'h1234);
    check(dly_adj, 16'h1234);
    wrchk(8'h0B, 16'h0100, 16'h0000);
    wrchk(8'h0B, 16'h00FF, 16'h00FF);
    check(imp, 16'h00FF);
    wrchk(8'h12, 16'h0002, 16'h0000);
    wrchk(8'h12, 16'h0001, 16'h0001);
    check({15'h0000, prof}, 16'h0001);
    wrchk(8'h0A, 16'h0002, 16'h0000);
    wrchk(8'h0A, 16'hFFFF, 16'hFFFF);
    wrchk(8'h0A, 16'h0001, 16'h0001);
    wrchk(8'h0A, 16'h0000, 16'h0000);
    wrchk(8'h13, 16'h0065, 16'h0008);
    wrchk(8'h13, 16'h0064, 16'h0064);
    wrchk(8'h13, 16'h0008, 16'h0008);
    wrchk(8'h14, 16'hFFFF, 16'hFFFF);
    wrchk(8'h14, 16'h0000, 16'h0000);
    wrchk(8'h15, 16'h0003, 16'h0001);
    wrchk(8'h16, 16'h0002, 16'h0000);
    wrchk(8'h09, 16'h1111, 16'h0000);
    wrchk(8'h0F, 16'h1111, 16'h0000);
    wrchk(8'h11, 16'h1111, gauge_pkg::CHIP_VER_VAL);
    // host temperature range, then thermistor source
    wrchk(8'h08, 16'h09E4, 16'h09E4);
    wrchk(8'h08, 16'h0D05, 16'h09E4);
    wrchk(8'h16, 16'h0001, 16'h0001);
    check({15'h0000, therm_mode}, 16'h0001);
    meas(1, 16'h0C00);
    rdchk(8'h08, 16'h0C00);
    wrchk(8'h08, 16'h0AAC, 16'h0C00);
    i_host.write_word(8'h16, 16'h0000);
    // automatic, present-voltage and history initialization
    meas(0, 16'd3800);
    wait_init();
    rdchk(8'h0F, 16'h0258);
    meas(0, 16'd4200);
    meas(0, 16'd3500);
    i_host.write_word(8'h07, 16'hAA55);
    wait_init();
    rdchk(8'h0F, 16'h0064);
    rdchk(8'h09, 16'h0DAC);
    i_host.write_word(8'h04, 16'hAA55);
    wait_init();
    rdchk(8'h0F, 16'h03E8);
    rdchk(8'h0D, 16'h0064);
    // reporting direction
    i_host.write_word(8'h0A, 16'h0001);
    meas(2, 16'd50);
    rdchk(8'h0F, 16'h03E8);
    i_host.write_word(8'h0A, 16'hFFFF);
    meas(2, 16'd500);
    rdchk(8'h0F, 16'h01F4);
    meas(2, 16'd700);
    rdchk(8'h0F, 16'h01F4);
    i_host.write_word(8'h0A, 16'h0000);
    meas(2, 16'd700);
    rdchk(8'h0F, 16'h02BC);
    // percent write and alarm levels
    i_host.write_word(8'h0D, 16'h0005);
    rdchk(8'h0F, 16'h0032);
    alarm_is(1'b0);
    i_host.write_word(8'h0D, 16'h0008);
    alarm_is(1'b0);
    i_host.write_word(8'h0D, 16'h0009);
    alarm_is(1'b1);
    i_host.write_word(8'h13, 16'h0000);
    i_host.write_word(8'h0D, 16'h0005);
    alarm_is(1'b1);
    i_host.write_word(8'h14, 16'h0E10);
    alarm_is(1'b0);
    i_host.write_word(8'h14, 16'h0000);
    alarm_is(1'b1);
    // sleep freezes measuring and tracking
    wrchk(8'h15, 16'h0002, 16'h0002);
    check({15'h0000, oper}, 16'h0000);
    meas(0, 16'd3900);
    meas(2, 16'd100);
    rdchk(8'h09, 16'h0DAC);
    rdchk(8'h0F, 16'h0032);
    i_host.write_word(8'h15, 16'h0001);
    alarm_is(1'b1);
    check({15'h0000, oper}, 16'h0001);
    conclude();
  end
endmodule : fuel_gauge_register_bank_tb

/* verification/gauge_bank_sva.sv */
// assertion checker for the charge estimator register bank
`timescale 1ns/100ps
module gauge_bank_sva #(
  parameter int INIT_LIMIT_CYC = 50
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] cmd_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic operational_o,
  input wire logic therm_mode_o,
  input wire logic init_busy_o,
  input wire logic [15:0] therm_beta_o,
  input wire logic profile_sel_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // initialization steps
  sequence init_cmd;
    wr_i && wdata_i == gauge_pkg::INIT_KEY && operational_o && !init_busy_o
    && (cmd_i == gauge_pkg::CMD_INIT_NOW
    || cmd_i == gauge_pkg::CMD_INIT_HISTORY);
  endsequence
  sequence init_finish;
    ##[1:INIT_LIMIT_CYC] !init_busy_o;
  endsequence
  a_init_start: assert property (init_cmd |-> ##2 init_busy_o)
    else $error("init command did not start");
  a_init_bound: assert property ($rose(init_busy_o) |-> init_finish)
    else $error("init not finished in time");
  // ==========================================================
  // register port
  a_read_answer: assert property (rd_i |=> rvalid_o)
    else $error("read not answered");
  a_no_stray_valid: assert property (!rd_i |=> !rvalid_o)
    else $error("answer without read");
  a_rdata_hold: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read word changed without read");
  a_chip_id: assert property (rd_i && cmd_i == gauge_pkg::CMD_CHIP_VER
    |=> rdata_o == gauge_pkg::CHIP_VER_VAL)
    else $error("wrong chip id");
  a_wo_read_zero: assert property (rd_i && cmd_i == gauge_pkg::CMD_INIT_NOW
    |=> rdata_o == 16'h0000)
    else $error("write-only read not zero");
  a_beta_write: assert property (wr_i && cmd_i == gauge_pkg::CMD_THERM_BETA
    |-> ##2 therm_beta_o == $past(wdata_i, 2))
    else $error("beta copy not updated");
  a_sleep_entry: assert property (wr_i && cmd_i == gauge_pkg::CMD_POWER_MODE
    && wdata_i == gauge_pkg::MODE_SLEEP |-> ##[1:2] !operational_o)
    else $error("sleep not entered");
  a_therm_needs_op: assert property ($fell(operational_o)
    |-> ##[0:2] !therm_mode_o)
    else $error("thermistor active in sleep");
  a_profile_guard: assert property (wr_i && cmd_i == 8'h12 && wdata_i > 16'h0001
    |-> ##2 profile_sel_o == $past(profile_sel_o, 2))
    else $error("bad profile value taken");
endmodule : gauge_bank_sva

bind fuel_gauge_register_bank gauge_bank_sva #(
  .INIT_LIMIT_CYC(INIT_LIMIT_CYC)
) i_sva (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .wr_i(wr_i),
  .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .operational_o(operational_o), .therm_mode_o(therm_mode_o),
  .init_busy_o(init_busy_o), .therm_beta_o(therm_beta_o),
  .profile_sel_o(profile_sel_o)
);

/* verification/host_bus_model.sv */
// host side master issuing whole word register accesses
`timescale 1ns/100ps
module host_bus_model (
  input wire logic mclk_i,
  input wire logic rvalid_i,
  input wire logic [15:0] rdata_i,
  output logic [7:0] cmd_o,
  output logic wr_o,
  output logic rd_o,
  output logic [15:0] wdata_o
);
  // idle lines at time zero
  initial begin
    cmd_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0000;
  end
  // one word write, strobe for one clock
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
    @(negedge mclk_i);
    cmd_o = cmd;
    wdata_o = data;
    wr_o = 1'b1;
    @(negedge mclk_i);
    wr_o = 1'b0;
    wdata_o = ~data; // released word does not linger
  endtask : write_word
  // one word read, waits a bounded time for the answer
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] data);
    int n;
    @(negedge mclk_i);
    cmd_o = cmd;
    rd_o = 1'b1;
    @(negedge mclk_i);
    rd_o = 1'b0;
    n = 0;
    data = 16'hXXXX;
    while (rvalid_i !== 1'b1 && n < 4) begin
      @(negedge mclk_i);
      n++;
    end
    if (rvalid_i === 1'b1) begin
      data = rdata_i;
    end
  endtask : read_word
endmodule : host_bus_model
